//--- rtl/pmx_cfg.svh
// constants of the management path multiplexer
// assumes inclusion by bare name from the package and the modules
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH
// register request widths
`define PMX_AW 8
`define PMX_DW 16
// requesters of the register ports, index and allow bit
`define PMX_NREQ 3
`define PMX_REQ_LDR 0
`define PMX_REQ_I2C 1
`define PMX_REQ_SER 2
`define PMX_ALLOW_LDR 3'h1
`define PMX_ALLOW_I2C 3'h2
`define PMX_ALLOW_SER 3'h4
// register port targets
`define PMX_TGT_PMM 2'h0
`define PMX_TGT_VPHY0 2'h1
`define PMX_TGT_VPHY1 2'h2
`define PMX_TGT_NONE 2'h3
// internal serial slaves and masters, pin synchroniser
`define PMX_NSLV 5
`define PMX_NMST 4
`define PMX_SYNC_RST 2'h1
`endif

//--- rtl/pmx_pkg.sv
// types of the management path multiplexer
// assumes pmx_cfg.svh sits on the include path
`include "pmx_cfg.svh"
package pmx_pkg;
   // port 0 management configurations
   typedef enum logic [2:0] {P0_MAC_SER, P0_MAC_SER_INIT, P0_PHY_SER,
      P0_PHY_SER_INIT, P0_MAC_I2C, P0_PHY_I2C} pmx_p0_mode_t;
   // port 1 configurations
   typedef enum logic [1:0] {P1_INT_PHY, P1_MAC, P1_PHY} pmx_p1_mode_t;
   // management masters
   typedef enum logic [1:0] {MS_NONE, MS_EXT0, MS_EXT1, MS_PMM}
      pmx_master_t;
   // management slaves, external phy last
   typedef enum logic [2:0] {SL_PHYA, SL_PHYB, SL_VPHY0, SL_VPHY1,
      SL_SER, SL_EXTPHY} pmx_slave_t;
   // one serial management line set
   typedef struct packed {
      logic mdc;
      logic mdio;
      logic oe;
   } pmx_mgmt_t;
   // register port request, one cycle pulse
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [1:0]        tgt;
      logic [`PMX_AW-1:0] addr;
      logic [`PMX_DW-1:0] wdata;
   } pmx_reg_req_t;
   // register port answer, one cycle pulse
   typedef struct packed {
      logic              ack;
      logic              err;
      logic [`PMX_DW-1:0] rdata;
   } pmx_reg_rsp_t;
endpackage

//--- rtl/pmx_pin_sync.sv
// three stage synchroniser for management pin inputs
// assumes pins are asynchronous to mclk
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_pin_sync #(
   parameter int         W       = 2,
   parameter logic [1:0] RST_VAL = `PMX_SYNC_RST
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // pin side and clean side
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

   // a change counts once stages two and three agree
   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   // stage registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q  <= RST_VAL[W-1:0];
         s2_q  <= RST_VAL[W-1:0];
         s3_q  <= RST_VAL[W-1:0];
         out_q <= RST_VAL[W-1:0];
      end else begin
         s1_q  <= din;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule

//--- rtl/pmx_reg_sel.sv
// register port selector: one requester per target access
// assumes requests are one cycle pulses, one outstanding each
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_reg_sel #(
   parameter logic [1:0] TGT = `PMX_TGT_PMM
) (
   // clock and reset
   input  wire logic                                 mclk,
   input  wire logic                                 rst,
   // requesters allowed by the current mode
   input  wire logic [`PMX_NREQ-1:0]                 allow,
   input  wire pmx_pkg::pmx_reg_req_t [`PMX_NREQ-1:0] req,
   output pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0]      rsp,
   // target register port
   output pmx_pkg::pmx_reg_req_t                     tgt_req,
   input  wire pmx_pkg::pmx_reg_rsp_t                tgt_rsp
);
   logic                                 busy_q, busy_d;
   logic [1:0]                           own_q, own_d;
   pmx_pkg::pmx_reg_req_t                treq_q, treq_d;
   pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0] rsp_q, rsp_d;

   // grant, refuse and return answers
   always_comb begin
      busy_d = busy_q;
      own_d  = own_q;
      treq_d = '0;
      rsp_d  = '0;
      if (busy_q && tgt_rsp.ack) begin
         busy_d = 1'b0;
         rsp_d[own_q] = tgt_rsp;
      end
      for (int i = `PMX_NREQ - 1; i >= 0; i--) begin
         if (req[i].valid && req[i].tgt == TGT) begin
            if (!busy_q && allow[i]) begin
               if (treq_d.valid) begin
                  rsp_d[own_d].ack = 1'b1; // outranked, refused
                  rsp_d[own_d].err = 1'b1;
               end
               own_d  = 2'(i);
               treq_d = req[i];
            end else begin
               rsp_d[i].ack = 1'b1; // busy or not routed
               rsp_d[i].err = 1'b1;
            end
         end
      end
      if (treq_d.valid) begin
         busy_d = 1'b1;
         if (own_d == 2'(`PMX_REQ_LDR)) begin
            treq_d.write = 1'b1; // loader only writes
         end
      end
   end

   // selector state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         own_q  <= 2'h0;
         treq_q <= '0;
         rsp_q  <= '0;
      end else begin
         busy_q <= busy_d;
         own_q  <= own_d;
         treq_q <= treq_d;
         rsp_q  <= rsp_d;
      end
   end

   assign tgt_req = treq_q;
   assign rsp     = rsp_q;
endmodule

//--- rtl/pmx_mux.sv
// management path multiplexer of a three port switch
// assumes mode inputs and register ports share mclk; pins do not
// Operation
// - port 0 phy serial: port 0 master reaches phys a, b, vphy0, serial slave
// - port 0 phy serial: internal master cut off once initialisation ends
// - port 0 phy serial init: phys to internal master, rest to pins
// - port 0 phy serial init: loader writes the internal master registers
// - port 0 phy serial init: loader reaches the vphy0 registers
// - port 0 mac i2c: internal master drives phys and external phy
// - port 0 mac i2c: i2c slave and loader reach internal master registers
// - port 0 phy i2c: phys to internal master, vphy0 to port 0 pins
// - port 1 internal phy: vphy1 idle, phy a follows port 0 mode
// - port 1 mac: vphy1 idle, its registers still reachable
// - port 1 mac: its external phy is managed over port 0 pins in port 0 mac i2c only
// - port 1 phy: port 1 master reaches vphy1; registers stay reachable
// - read data follows the chosen slave; pin enables set here
// - port 0 mac serial: port 0 master reaches phys and serial slave
// - port 0 mac serial init: phys to internal master, serial to pins
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_mux (
   // clock and reset
   input  wire logic                                 mclk,
   input  wire logic                                 rst,
   // mode inputs
   input  wire logic                                 port0_mac_mode,
   input  wire logic                                 i2c_managed,
   input  wire logic                                 init_busy,
   input  wire pmx_pkg::pmx_p1_mode_t                port1_mode,
   // mode status
   output pmx_pkg::pmx_p0_mode_t                     p0_mode,
   output pmx_pkg::pmx_p1_mode_t                     p1_mode,
   // port 0 management pins
   input  wire logic                                 p0_mdc_i,
   output logic                                      p0_mdc_o,
   output logic                                      p0_mdc_oe,
   input  wire logic                                 p0_mdio_i,
   output logic                                      p0_mdio_o,
   output logic                                      p0_mdio_oe,
   // port 1 management pins
   input  wire logic                                 p1_mdc_i,
   input  wire logic                                 p1_mdio_i,
   output logic                                      p1_mdio_o,
   output logic                                      p1_mdio_oe,
   // internal phy management master, serial side
   input  wire pmx_pkg::pmx_mgmt_t                   pmm_drv,
   output logic                                      pmm_mdio_in,
   // internal serial slaves: phy a, phy b, vphy0, vphy1, serial
   output pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0]        slv_drv,
   input  wire pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0]   slv_ret,
   // register requesters: loader, i2c slave, serial slave
   input  wire pmx_pkg::pmx_reg_req_t [`PMX_NREQ-1:0] reg_req,
   output pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0]      reg_rsp,
   // register ports: internal master, vphy0, vphy1
   output pmx_pkg::pmx_reg_req_t                     pmm_reg_req,
   input  wire pmx_pkg::pmx_reg_rsp_t                pmm_reg_rsp,
   output pmx_pkg::pmx_reg_req_t                     vphy0_reg_req,
   input  wire pmx_pkg::pmx_reg_rsp_t                vphy0_reg_rsp,
   output pmx_pkg::pmx_reg_req_t                     vphy1_reg_req,
   input  wire pmx_pkg::pmx_reg_rsp_t                vphy1_reg_rsp
);
   // ************************************************
   // decoding functions
   // ************************************************

   // master that owns a slave in the given modes
   function automatic pmx_pkg::pmx_master_t master_of(
      input pmx_pkg::pmx_slave_t   s,
      input pmx_pkg::pmx_p0_mode_t m0,
      input pmx_pkg::pmx_p1_mode_t m1);
      pmx_pkg::pmx_master_t r;
      r = pmx_pkg::MS_NONE;
      case (s)
         pmx_pkg::SL_PHYA, pmx_pkg::SL_PHYB: begin
            if (m0 == pmx_pkg::P0_MAC_SER || m0 == pmx_pkg::P0_PHY_SER) begin
               r = pmx_pkg::MS_EXT0;
            end else begin
               r = pmx_pkg::MS_PMM;
            end
         end
         pmx_pkg::SL_VPHY0: begin
            if (m0 == pmx_pkg::P0_PHY_SER || m0 == pmx_pkg::P0_PHY_SER_INIT ||
                m0 == pmx_pkg::P0_PHY_I2C) begin
               r = pmx_pkg::MS_EXT0;
            end
         end
         pmx_pkg::SL_VPHY1: begin
            if (m1 == pmx_pkg::P1_PHY) begin
               r = pmx_pkg::MS_EXT1;
            end
         end
         pmx_pkg::SL_SER: begin
            if (m0 != pmx_pkg::P0_MAC_I2C && m0 != pmx_pkg::P0_PHY_I2C) begin
               r = pmx_pkg::MS_EXT0;
            end
         end
         pmx_pkg::SL_EXTPHY: begin
            if (m0 == pmx_pkg::P0_MAC_I2C) begin
               r = pmx_pkg::MS_PMM;
            end
         end
         default: r = pmx_pkg::MS_NONE;
      endcase
      return r;
   endfunction

   // requesters allowed onto a register port
   function automatic logic [`PMX_NREQ-1:0] allow_of(
      input logic [1:0]            tgt,
      input pmx_pkg::pmx_p0_mode_t m0);
      logic init;
      logic i2c;
      logic [`PMX_NREQ-1:0] a;
      init = (m0 == pmx_pkg::P0_MAC_SER_INIT) ||
             (m0 == pmx_pkg::P0_PHY_SER_INIT);
      i2c  = (m0 == pmx_pkg::P0_MAC_I2C) || (m0 == pmx_pkg::P0_PHY_I2C);
      a    = `PMX_ALLOW_LDR;
      if (init && tgt != `PMX_TGT_VPHY1) begin
         a = `PMX_ALLOW_LDR;
      end else if (i2c && (tgt != `PMX_TGT_VPHY0 ||
                           m0 == pmx_pkg::P0_PHY_I2C)) begin
         a = `PMX_ALLOW_LDR | `PMX_ALLOW_I2C;
      end else begin
         a = `PMX_ALLOW_LDR | `PMX_ALLOW_SER;
      end
      return a;
   endfunction

   // ************************************************
   // mode register
   // ************************************************

   pmx_pkg::pmx_p0_mode_t m0_q, m0_d;
   pmx_pkg::pmx_p1_mode_t m1_q, m1_d;
   // current configuration from the mode inputs
   always_comb begin
      m1_d = port1_mode;
      case ({i2c_managed, port0_mac_mode})
         2'h0: m0_d = init_busy ? pmx_pkg::P0_PHY_SER_INIT
                                : pmx_pkg::P0_PHY_SER;
         2'h1: m0_d = init_busy ? pmx_pkg::P0_MAC_SER_INIT
                                : pmx_pkg::P0_MAC_SER;
         2'h2: m0_d = pmx_pkg::P0_PHY_I2C;
         2'h3: m0_d = pmx_pkg::P0_MAC_I2C;
         default: m0_d = pmx_pkg::P0_MAC_SER_INIT;
      endcase
   end

   // mode registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         m0_q <= pmx_pkg::P0_MAC_SER_INIT;
         m1_q <= pmx_pkg::P1_INT_PHY;
      end else begin
         m0_q <= m0_d;
         m1_q <= m1_d;
      end
   end

   assign p0_mode = m0_q;
   assign p1_mode = m1_q;

   // ************************************************
   // pin synchronisers
   // ************************************************

   logic [1:0] p0_s;
   logic [1:0] p1_s;

   // port 0 pins, mdio in bit 0
   pmx_pin_sync #(.W(2), .RST_VAL(`PMX_SYNC_RST)) u_sync0 (
      .mclk (mclk),
      .rst  (rst),
      .din  ({p0_mdc_i, p0_mdio_i}),
      .dout (p0_s)
   );

   // port 1 pins, mdio in bit 0
   pmx_pin_sync #(.W(2), .RST_VAL(`PMX_SYNC_RST)) u_sync1 (
      .mclk (mclk),
      .rst  (rst),
      .din  ({p1_mdc_i, p1_mdio_i}),
      .dout (p1_s)
   );

   // ************************************************
   // serial management path
   // ************************************************

   pmx_pkg::pmx_master_t                  slv_m [`PMX_NSLV];
   pmx_pkg::pmx_master_t                  ext_m;
   pmx_pkg::pmx_mgmt_t                    src [`PMX_NMST];
   pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0]    slv_q, slv_d;
   logic [`PMX_NMST-1:0]                  rd_oe, rd_dat;
   logic p0_mdc_q, p0_mdc_d, p0_mdc_oe_q, p0_mdc_oe_d;
   logic p0_mdio_q, p0_mdio_d, p0_mdio_oe_q, p0_mdio_oe_d;
   logic p1_mdio_q, p1_mdio_d, p1_mdio_oe_q, p1_mdio_oe_d;
   logic pmm_in_q, pmm_in_d;

   // owner of each internal slave, one per slave
   genvar g;
   generate
      for (g = 0; g < `PMX_NSLV; g++) begin : g_own
         assign slv_m[g] = master_of(pmx_pkg::pmx_slave_t'(g), m0_q, m1_q);
      end
   endgenerate
   assign ext_m = master_of(pmx_pkg::SL_EXTPHY, m0_q, m1_q);

   // drive of each master; an absent master idles mdio high
   always_comb begin
      src[pmx_pkg::MS_NONE] = '{mdc: 1'b0, mdio: 1'b1, oe: 1'b0};
      src[pmx_pkg::MS_EXT0] = '{mdc: p0_s[1], mdio: p0_s[0], oe: 1'b1};
      src[pmx_pkg::MS_EXT1] = '{mdc: p1_s[1], mdio: p1_s[0], oe: 1'b1};
      src[pmx_pkg::MS_PMM]  = pmm_drv;
   end

   // slave drive and read data merge per master
   always_comb begin
      rd_oe  = '0;
      rd_dat = '1;
      for (int s = 0; s < `PMX_NSLV; s++) begin
         slv_d[s] = src[slv_m[s]];
         if (slv_m[s] != pmx_pkg::MS_NONE && slv_ret[s].oe) begin
            rd_oe[slv_m[s]]  = 1'b1;
            rd_dat[slv_m[s]] = rd_dat[slv_m[s]] & slv_ret[s].mdio;
         end
      end
      if (ext_m == pmx_pkg::MS_PMM && !pmm_drv.oe) begin
         rd_dat[pmx_pkg::MS_PMM] = rd_dat[pmx_pkg::MS_PMM] & p0_s[0];
      end
   end

   // pin outputs and internal master read data
   always_comb begin
      pmm_in_d     = rd_dat[pmx_pkg::MS_PMM];
      p1_mdio_d    = rd_dat[pmx_pkg::MS_EXT1];
      p1_mdio_oe_d = rd_oe[pmx_pkg::MS_EXT1];
      if (ext_m == pmx_pkg::MS_PMM) begin
         p0_mdc_d     = pmm_drv.mdc;
         p0_mdc_oe_d  = 1'b1;
         p0_mdio_d    = pmm_drv.mdio;
         p0_mdio_oe_d = pmm_drv.oe;
      end else begin
         p0_mdc_d     = 1'b0;
         p0_mdc_oe_d  = 1'b0;
         p0_mdio_d    = rd_dat[pmx_pkg::MS_EXT0];
         p0_mdio_oe_d = rd_oe[pmx_pkg::MS_EXT0];
      end
   end

   // serial path registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slv_q        <= {`PMX_NSLV{3'h2}};
         p0_mdc_q     <= 1'b0;
         p0_mdc_oe_q  <= 1'b0;
         p0_mdio_q    <= 1'b1;
         p0_mdio_oe_q <= 1'b0;
         p1_mdio_q    <= 1'b1;
         p1_mdio_oe_q <= 1'b0;
         pmm_in_q     <= 1'b1;
      end else begin
         slv_q        <= slv_d;
         p0_mdc_q     <= p0_mdc_d;
         p0_mdc_oe_q  <= p0_mdc_oe_d;
         p0_mdio_q    <= p0_mdio_d;
         p0_mdio_oe_q <= p0_mdio_oe_d;
         p1_mdio_q    <= p1_mdio_d;
         p1_mdio_oe_q <= p1_mdio_oe_d;
         pmm_in_q     <= pmm_in_d;
      end
   end

   assign slv_drv     = slv_q;
   assign p0_mdc_o    = p0_mdc_q;
   assign p0_mdc_oe   = p0_mdc_oe_q;
   assign p0_mdio_o   = p0_mdio_q;
   assign p0_mdio_oe  = p0_mdio_oe_q;
   assign p1_mdio_o   = p1_mdio_q;
   assign p1_mdio_oe  = p1_mdio_oe_q;
   assign pmm_mdio_in = pmm_in_q;

   // ************************************************
   // register port selection
   // ************************************************

   pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0] r_pmm, r_v0, r_v1;
   pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0] rsp_q, rsp_d;

   // internal master register port
   pmx_reg_sel #(.TGT(`PMX_TGT_PMM)) u_sel_pmm (
      .mclk    (mclk),
      .rst     (rst),
      .allow   (allow_of(`PMX_TGT_PMM, m0_q)),
      .req     (reg_req),
      .rsp     (r_pmm),
      .tgt_req (pmm_reg_req),
      .tgt_rsp (pmm_reg_rsp)
   );

   // virtual phy 0 register port
   pmx_reg_sel #(.TGT(`PMX_TGT_VPHY0)) u_sel_v0 (
      .mclk    (mclk),
      .rst     (rst),
      .allow   (allow_of(`PMX_TGT_VPHY0, m0_q)),
      .req     (reg_req),
      .rsp     (r_v0),
      .tgt_req (vphy0_reg_req),
      .tgt_rsp (vphy0_reg_rsp)
   );

   // virtual phy 1 register port
   pmx_reg_sel #(.TGT(`PMX_TGT_VPHY1)) u_sel_v1 (
      .mclk    (mclk),
      .rst     (rst),
      .allow   (allow_of(`PMX_TGT_VPHY1, m0_q)),
      .req     (reg_req),
      .rsp     (r_v1),
      .tgt_req (vphy1_reg_req),
      .tgt_rsp (vphy1_reg_rsp)
   );

   // merge answers; an unknown target is refused at once
   always_comb begin
      rsp_d = r_pmm | r_v0 | r_v1;
      for (int i = 0; i < `PMX_NREQ; i++) begin
         if (reg_req[i].valid && reg_req[i].tgt == `PMX_TGT_NONE) begin
            rsp_d[i].ack = 1'b1;
            rsp_d[i].err = 1'b1;
         end
      end
   end

   // answer registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign reg_rsp = rsp_q;
endmodule

//--- verif/pmx_mux_properties.sv
// assertions on the ports of the management path multiplexer
// assumes the rtl package is compiled first; bound into pmx_mux
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_mux_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // status and serial side
   input wire pmx_pkg::pmx_p0_mode_t p0_mode,
   input wire pmx_pkg::pmx_p1_mode_t p1_mode,
   input wire logic p0_mdc_oe,
   input wire logic pmm_mdio_in,
   input wire pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0] slv_drv,
   // register side
   input wire pmx_pkg::pmx_reg_req_t [`PMX_NREQ-1:0] reg_req,
   input wire pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0] reg_rsp,
   input wire pmx_pkg::pmx_reg_req_t pmm_reg_req,
   input wire pmx_pkg::pmx_reg_rsp_t pmm_reg_rsp
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ********************
   // routing
   // ********************
   pin_clock_a: assert property (p0_mdc_oe |->
      $past(p0_mode) == pmx_pkg::P0_MAC_I2C) else $error("mdc driven");
   vphy1_idle_a: assert property (slv_drv[3].oe |->
      $past(p1_mode) == pmx_pkg::P1_PHY) else $error("vphy1 busy");
   pmm_cut_a: assert property ((p0_mode == pmx_pkg::P0_PHY_SER)[*3]
      |-> pmm_mdio_in) else $error("internal master still fed");
   ser_unrouted_a: assert property (
      (p0_mode == pmx_pkg::P0_MAC_I2C)[*3] |-> slv_drv[4] == 3'h2)
      else $error("serial slave routed");
   // ********************
   // register ports
   // ********************
   tgt_cause_a: assert property (pmm_reg_req.valid |->
      $past(reg_req[0].valid || reg_req[1].valid || reg_req[2].valid))
      else $error("target request without cause");
   tgt_pulse_a: assert property (pmm_reg_req.valid |=>
      !pmm_reg_req.valid) else $error("target request held");
   ldr_write_a: assert property (pmm_reg_req.valid &&
      $past(reg_req[0].valid && reg_req[0].tgt == 2'h0) |->
      pmm_reg_req.write)
      else $error("loader read passed on");
   rsp_back_a: assert property (pmm_reg_rsp.ack |-> ##[2:3]
      (reg_rsp[0].ack || reg_rsp[1].ack || reg_rsp[2].ack))
      else $error("answer lost");
   bad_tgt_a: assert property (reg_req[1].valid &&
      reg_req[1].tgt == 2'h3 |-> ##1 reg_rsp[1].ack && reg_rsp[1].err)
      else $error("bad target not refused");
endmodule

bind pmx_mux pmx_mux_properties i_pmx_mux_properties (.mclk(mclk),
   .rst(rst), .p0_mode(p0_mode), .p1_mode(p1_mode), .p0_mdc_oe(p0_mdc_oe),
   .pmm_mdio_in(pmm_mdio_in), .slv_drv(slv_drv), .reg_req(reg_req),
   .reg_rsp(reg_rsp), .pmm_reg_req(pmm_reg_req), .pmm_reg_rsp(pmm_reg_rsp));

//--- verif/pmx_host.sv
// model of an external management host on one set of mii pins
// assumes the bench resolves the pin with a pull-up
`timescale 1ns/10ps
module pmx_host (
   // clock
   input wire logic mclk,
   // pin side
   output logic     mdc,
   output logic     mdio_o,
   output logic     mdio_oe
);
   // clock parked low between frames, line released
   initial begin
      mdc = 1'b0;
      mdio_o = 1'b1;
      mdio_oe = 1'b0;
   end
   // drive a level, only toward slaves routed to these pins
   task put(input logic b);
      @(posedge mclk);
      mdio_oe <= 1'b1;
      mdio_o <= b;
   endtask
   // let go; the pull-up takes the line
   task free();
      @(posedge mclk);
      mdio_oe <= 1'b0;
      mdio_o <= ~mdio_o;
   endtask
endmodule

//--- verif/pmx_mux_test.sv
// self-checking bench of the management path multiplexer
// assumes the rtl files and one host model per port
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_mux_test;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic port0_mac_mode = 1'b0;
   logic i2c_managed = 1'b0;
   logic init_busy = 1'b0;
   pmx_pkg::pmx_p1_mode_t port1_mode = pmx_pkg::P1_INT_PHY;
   pmx_pkg::pmx_p0_mode_t p0_mode;
   pmx_pkg::pmx_p1_mode_t p1_mode;
   logic p0_mdc_o, p0_mdc_oe, p0_mdio_o, p0_mdio_oe;
   logic p1_mdio_o, p1_mdio_oe, pmm_mdio_in;
   logic h0_mdc, h0_o, h0_oe, h1_mdc, h1_o, h1_oe;
   // pin levels: pull-up on both data lines
   wire p0_mdc_i = p0_mdc_oe ? p0_mdc_o : h0_mdc;
   wire p0_mdio_i = h0_oe ? h0_o : p0_mdio_oe ? p0_mdio_o : 1'b1;
   wire p1_mdc_i = h1_mdc;
   wire p1_mdio_i = h1_oe ? h1_o : p1_mdio_oe ? p1_mdio_o : 1'b1;
   pmx_pkg::pmx_mgmt_t pmm_drv = 3'h2;
   pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0] slv_drv;
   pmx_pkg::pmx_mgmt_t [`PMX_NSLV-1:0] slv_ret = 15'h2492;
   pmx_pkg::pmx_reg_req_t [`PMX_NREQ-1:0] reg_req = '0;
   pmx_pkg::pmx_reg_rsp_t [`PMX_NREQ-1:0] reg_rsp;
   pmx_pkg::pmx_reg_req_t pmm_reg_req, vphy0_reg_req, vphy1_reg_req;
   pmx_pkg::pmx_reg_rsp_t pmm_reg_rsp = '0;
   pmx_pkg::pmx_reg_rsp_t vphy0_reg_rsp = '0;
   pmx_pkg::pmx_reg_rsp_t vphy1_reg_rsp = '0;
   int num_errors = 0;
   int checks = 0;

   initial begin
      forever #2.5 mclk = ~mclk;
   end
   pmx_mux i_pmx_mux (.mclk(mclk), .rst(rst),
      .port0_mac_mode(port0_mac_mode), .i2c_managed(i2c_managed),
      .init_busy(init_busy), .port1_mode(port1_mode), .p0_mode(p0_mode),
      .p1_mode(p1_mode), .p0_mdc_i(p0_mdc_i), .p0_mdc_o(p0_mdc_o),
      .p0_mdc_oe(p0_mdc_oe), .p0_mdio_i(p0_mdio_i), .p0_mdio_o(p0_mdio_o),
      .p0_mdio_oe(p0_mdio_oe), .p1_mdc_i(p1_mdc_i), .p1_mdio_i(p1_mdio_i),
      .p1_mdio_o(p1_mdio_o), .p1_mdio_oe(p1_mdio_oe), .pmm_drv(pmm_drv),
      .pmm_mdio_in(pmm_mdio_in), .slv_drv(slv_drv), .slv_ret(slv_ret),
      .reg_req(reg_req), .reg_rsp(reg_rsp), .pmm_reg_req(pmm_reg_req),
      .pmm_reg_rsp(pmm_reg_rsp), .vphy0_reg_req(vphy0_reg_req),
      .vphy0_reg_rsp(vphy0_reg_rsp), .vphy1_reg_req(vphy1_reg_req),
      .vphy1_reg_rsp(vphy1_reg_rsp));
   pmx_host i_pmx_host0 (.mclk(mclk), .mdc(h0_mdc), .mdio_o(h0_o),
      .mdio_oe(h0_oe));
   pmx_host i_pmx_host1 (.mclk(mclk), .mdc(h1_mdc), .mdio_o(h1_o),
      .mdio_oe(h1_oe));
   // register targets answer one cycle after each request
   always @(posedge mclk) begin
      pmm_reg_rsp <= {pmm_reg_req.valid, 1'b0, 16'h1234};
      vphy0_reg_rsp <= {vphy0_reg_req.valid, 1'b0, 16'h5678};
      vphy1_reg_rsp <= {vphy1_reg_req.valid, 1'b0, 16'h9abc};
   end
   // ********************
   // shared tasks
   // ********************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up();
      $display("errors %0d, checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task set_mode(input logic mac, input logic i2c, input logic busy);
      @(posedge mclk);
      port0_mac_mode <= mac;
      i2c_managed <= i2c;
      init_busy <= busy;
      repeat (8) @(posedge mclk);
      #1;
   endtask
   // one request, bounded wait for the answer pulse
   task req(input int i, input logic [1:0] t, input logic err);
      int n;
      logic [15:0] rd;
      rd = (t == 2'h0) ? 16'h1234 : (t == 2'h1) ? 16'h5678 : 16'h9abc;
      @(posedge mclk);
      reg_req[i] <= {1'b1, 1'b0, t, 8'h01, 16'h0000};
      @(posedge mclk);
      reg_req[i] <= '0;
      #1;
      n = 0;
      while (reg_rsp[i].ack !== 1'b1 && n < 10) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check({reg_rsp[i].ack, reg_rsp[i].err}, {1'b1, err});
      if (!err)
         check(reg_rsp[i].rdata, rd);
   endtask
   // ********************
   // scenarios
   // ********************
   task t_init();
      pmm_drv <= {1'b0, 1'b0, 1'b1};
      set_mode(1'b0, 1'b0, 1'b1);
      check(p0_mode, pmx_pkg::P0_PHY_SER_INIT);
      check({slv_drv[0].mdio, slv_drv[2].mdio}, 2'h1);
      req(0, 2'h0, 1'b0);
      req(0, 2'h1, 1'b0);
      req(2, 2'h0, 1'b1);
   endtask
   task t_phy_ser();
      set_mode(1'b0, 1'b0, 1'b0);
      check(p0_mode, pmx_pkg::P0_PHY_SER);
      check(slv_drv[0].mdio, 1'b1);
      i_pmx_host0.put(1'b0);
      repeat (8) @(posedge mclk);
      #1;
      check({slv_drv[0].mdio, slv_drv[1].mdio, slv_drv[2].mdio,
         slv_drv[4].mdio}, 4'h0);
      i_pmx_host0.free();
      slv_ret[2] <= {1'b0, 1'b0, 1'b1};
      repeat (4) @(posedge mclk);
      #1;
      check({p0_mdio_oe, p0_mdio_o, pmm_mdio_in}, 3'h5);
      slv_ret[2] <= 3'h2;
   endtask
   task t_mac_i2c();
      port1_mode <= pmx_pkg::P1_MAC;
      pmm_drv <= {1'b1, 1'b0, 1'b1};
      set_mode(1'b1, 1'b1, 1'b0);
      check(p0_mode, pmx_pkg::P0_MAC_I2C);
      check({p0_mdc_oe, p0_mdc_o, p0_mdio_oe, p0_mdio_o}, 4'he);
      check({slv_drv[0].mdio, slv_drv[4]}, 4'h2);
      check(slv_drv[3], 3'h2);
      req(1, 2'h0, 1'b0);
      req(2, 2'h0, 1'b1);
      req(1, 2'h3, 1'b1);
      pmm_drv <= 3'h2;
   endtask
   task t_p1_phy();
      port1_mode <= pmx_pkg::P1_PHY;
      i_pmx_host1.put(1'b0);
      repeat (8) @(posedge mclk);
      #1;
      check(p1_mode, pmx_pkg::P1_PHY);
      check({slv_drv[3].oe, slv_drv[3].mdio}, 2'h2);
      req(1, 2'h2, 1'b0);
      i_pmx_host1.free();
      slv_ret[3] <= {1'b0, 1'b0, 1'b1};
      repeat (2) @(posedge mclk);
      #1;
      check({p1_mdio_oe, p1_mdio_o}, 2'h2);
      @(posedge mclk);
      slv_ret[3] <= 3'h2;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      check(p0_mode, pmx_pkg::P0_MAC_SER_INIT);
      check({p0_mdc_oe, p0_mdio_oe, p1_mdio_oe}, 3'h0);
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_init();
      t_phy_ser();
      t_mac_i2c();
      t_p1_phy();
      wrap_up();
   end
   // watchdog against a hang
   initial begin
      repeat (3000) @(posedge mclk);
      num_errors++;
      wrap_up();
   end
endmodule
